// ===== hw/rhtm_sensor_if.sv
/*
  Command decoder and result readout of a humidity/temperature sensor
  behind a two-wire serial slave; results come from a measurement engine.
  Assumes SCL/SDA/address pins are asynchronous to clk and that each SCL
  phase lasts at least four clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rhtm_sensor_if #(
  parameter int unsigned TICK_CYCLES = rhtm_pkg::TICK_CYCLES,
  parameter logic [7:0]  CRC_POLY    = rhtm_pkg::CRC_POLY_DEF,
  parameter logic [7:0]  CRC_INIT    = rhtm_pkg::CRC_INIT_DEF,
  parameter logic [15:0] BREAK_CMD   = 16'hb0b0, // Arbitrary code
  parameter logic [15:0] FETCH_CMD   = 16'hf0f0, // Arbitrary code
  parameter int unsigned FIFO_DEPTH  = rhtm_pkg::FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_sel,
  input  wire logic        res_valid,
  output logic             res_ready,
  input  wire logic [15:0] res_temp,
  input  wire logic [15:0] res_hum,
  output logic             meas_start,
  output logic             meas_abort,
  output logic [1:0]       meas_rep,
  output logic             periodic_mode,
  output logic             data_present
);
  import rhtm_pkg::*;

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    logic       fb;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

  // Result: {valid, periodic, stretch, rep[1:0], rate[2:0]}
  function automatic logic [7:0] decode(input logic [15:0] c);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 3; i++) begin
      if (c == {SS_MSB_STR, SS_LSB_STR[i]}) begin
        r = {3'b101, 2'(i), 3'h0};
      end
      if (c == {SS_MSB_NOSTR, SS_LSB_NOSTR[i]}) begin
        r = {3'b100, 2'(i), 3'h0};
      end
      for (int j = 0; j < NUM_RATES; j++) begin
        if (c == {PER_MSB[j], PER_LSB[j][i]}) begin
          r = {3'b110, 2'(i), 3'(j)};
        end
      end
    end
    if (c == ART_CMD) begin
      r = {3'b110, 2'h0, RATE_ART};
    end
    return r;
  endfunction

  // Pin synchronisers; only the second stage is read
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] adr_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      adr_sync_reg <= 2'h0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      adr_sync_reg <= {adr_sync_reg[0], addr_sel};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  rhtm_state_type    state_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        cmd_msb_reg;
  logic [3:0]        bit_cnt_reg;
  logic [1:0]        phase_reg;
  logic [2:0]        tx_idx_reg;
  logic [47:0]       tx_buf_reg;
  logic              is_rd_reg;
  logic              tx_ok_reg;
  logic              sda_oe_reg;
  logic              scl_oe_reg;
  logic              periodic_reg;
  logic              stretch_reg;
  logic              pend_reg;
  logic [1:0]        rep_reg;
  logic [2:0]        rate_reg;
  logic              meas_start_reg;
  logic              meas_abort_reg;
  logic [31:0]       tick_cnt_reg;
  logic [5:0]        per_cnt_reg;
  logic              store_valid_reg;
  logic [PAIR_W-1:0] store_data_reg;
  logic              fifo_valid;
  logic [PAIR_W-1:0] fifo_data;

  wire        scl_s     = scl_sync_reg[1];
  wire        sda_s     = sda_sync_reg[1];
  wire        scl_rise  = scl_s & ~scl_d_reg;
  wire        scl_fall  = ~scl_s & scl_d_reg;
  wire        start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire        stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire [6:0]  my_addr   = adr_sync_reg[1] ? ADDR_HI : ADDR_LO;
  wire        byte_done = (state_reg == ST_RECV) & scl_fall & (bit_cnt_reg == BYTE_BITS);
  wire        addr_hit  = (phase_reg == PH_ADDR) & (shift_reg[7:1] == my_addr);
  wire        rd_hdr    = addr_hit & shift_reg[0];
  wire        rd_wait   = stretch_reg & pend_reg;
  wire        rd_ack    = rd_hdr & (store_valid_reg | rd_wait);
  wire [15:0] cmd_word  = {cmd_msb_reg, shift_reg};
  wire [7:0]  dec       = decode(cmd_word);
  wire        is_break  = (cmd_word == BREAK_CMD);
  wire        is_fetch  = (cmd_word == FETCH_CMD);
  wire        cmd_ok    = (phase_reg == PH_LSB) & (dec[7] | is_break | is_fetch);
  wire        ack_now   = (addr_hit & (~shift_reg[0] | rd_ack))
                        | (phase_reg == PH_MSB) | cmd_ok;
  wire        cmd_go    = byte_done & cmd_ok;
  wire        meas_go   = cmd_go & dec[7] & ~is_break & ~is_fetch;
  wire        brk_go    = cmd_go & is_break;
  wire        hold_go   = (state_reg == ST_HOLD) & store_valid_reg;
  wire        load_w    = (byte_done & rd_hdr & store_valid_reg) | hold_go;
  wire        pop       = fifo_valid & ~store_valid_reg;
  wire        tick      = (tick_cnt_reg == TICK_CYCLES - 1);
  wire        per_due   = tick & (per_cnt_reg == PER_TICKS[rate_reg] - 6'h01);
  wire [15:0] ld_t      = store_data_reg[31:16];
  wire [15:0] ld_h      = store_data_reg[15:0];

  // Engine may stall on a full buffer; results wait until read
  rhtm_fifo #(
    .WIDTH (PAIR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .flush     (brk_go),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   ({res_temp, res_hum}),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // Mode and measurement scheduling
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periodic_reg <= 1'b0;
      stretch_reg  <= 1'b0;
      rep_reg      <= 2'h0;
      rate_reg     <= 3'h0;
    end else if (brk_go) begin
      periodic_reg <= 1'b0;
      stretch_reg  <= 1'b0;
    end else if (meas_go) begin
      periodic_reg <= dec[6];
      stretch_reg  <= dec[5] & ~dec[6];
      rep_reg      <= dec[4:3];
      rate_reg     <= dec[2:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= '0;
      per_cnt_reg  <= '0;
    end else if (meas_go | ~periodic_reg) begin
      tick_cnt_reg <= '0;
      per_cnt_reg  <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
      per_cnt_reg  <= per_due ? 6'h00 : per_cnt_reg + 6'h01;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meas_start_reg <= 1'b0;
      meas_abort_reg <= 1'b0;
      pend_reg       <= 1'b0;
    end else begin
      meas_start_reg <= meas_go | (periodic_reg & per_due & ~brk_go);
      meas_abort_reg <= brk_go;
      pend_reg       <= (meas_go & ~dec[6]) | (pend_reg & ~pop & ~brk_go & ~meas_go);
    end
  end

  // One stored pair; taking it for readout empties it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      store_valid_reg <= 1'b0;
      store_data_reg  <= '0;
    end else if (brk_go) begin
      store_valid_reg <= 1'b0;
    end else if (pop) begin
      store_valid_reg <= 1'b1;
      store_data_reg  <= fifo_data;
    end else if (load_w) begin
      store_valid_reg <= 1'b0;
    end
  end

  // Serial slave
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= ST_IDLE;
      shift_reg   <= '0;
      cmd_msb_reg <= '0;
      bit_cnt_reg <= '0;
      phase_reg   <= PH_ADDR;
      tx_idx_reg  <= '0;
      tx_buf_reg  <= '0;
      is_rd_reg   <= 1'b0;
      tx_ok_reg   <= 1'b0;
      sda_oe_reg  <= 1'b0;
      scl_oe_reg  <= 1'b0;
    end else if (stop_det) begin
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg   <= ST_RECV;
      phase_reg   <= PH_ADDR;
      bit_cnt_reg <= '0;
      sda_oe_reg  <= 1'b0;
    end else begin
      if (load_w) begin
        tx_buf_reg <= {ld_t, crc8(ld_t), ld_h, crc8(ld_h)};
      end
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_RECV: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_done) begin
            sda_oe_reg  <= ack_now;
            state_reg   <= ack_now ? ST_ACK : ST_IDLE;
            is_rd_reg   <= rd_hdr;
            tx_ok_reg   <= store_valid_reg;
            cmd_msb_reg <= shift_reg;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= '0;
            tx_idx_reg  <= '0;
            if (is_rd_reg && tx_ok_reg) begin
              sda_oe_reg <= ~tx_buf_reg[47];
              state_reg  <= ST_SEND;
            end else if (is_rd_reg) begin
              sda_oe_reg <= 1'b0;
              scl_oe_reg <= 1'b1;
              state_reg  <= ST_HOLD;
            end else begin
              sda_oe_reg <= 1'b0;
              phase_reg  <= phase_reg + 2'h1;
              state_reg  <= (phase_reg == PH_LSB) ? ST_IDLE : ST_RECV;
            end
          end
        end
        ST_HOLD: begin
          if (store_valid_reg) begin
            sda_oe_reg <= ~ld_t[15]; // Data settles before clock release
            state_reg  <= ST_REL;
          end
        end
        ST_REL: begin
          scl_oe_reg <= 1'b0;
          state_reg  <= ST_SEND;
        end
        ST_SEND: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            tx_buf_reg  <= {tx_buf_reg[46:0], 1'b0};
            sda_oe_reg  <= (bit_cnt_reg == LAST_BIT) ? 1'b0 : ~tx_buf_reg[46];
            state_reg   <= (bit_cnt_reg == LAST_BIT) ? ST_MACK : ST_SEND;
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (!sda_s && tx_idx_reg != LAST_BYTE) begin
              tx_idx_reg <= tx_idx_reg + 3'h1;
              state_reg  <= ST_NEXT;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_NEXT: begin
          if (scl_fall) begin
            bit_cnt_reg <= '0;
            sda_oe_reg  <= ~tx_buf_reg[47];
            state_reg   <= ST_SEND;
          end
        end
      endcase
    end
  end

  assign scl_out       = 1'b0;
  assign sda_out       = 1'b0;
  assign scl_oe        = scl_oe_reg;
  assign sda_oe        = sda_oe_reg;
  assign meas_start    = meas_start_reg;
  assign meas_abort    = meas_abort_reg;
  assign meas_rep      = rep_reg;
  assign periodic_mode = periodic_reg;
  assign data_present  = store_valid_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_rd_nodata;
    byte_done && rd_hdr && !store_valid_reg && !rd_wait && !start_det && !stop_det;
  endsequence
  sequence s_hold_done;
    state_reg == ST_HOLD && store_valid_reg && !stop_det && !start_det;
  endsequence
  sequence s_release;
    state_reg == ST_REL ##1 (state_reg == ST_SEND && !scl_oe_reg);
  endsequence

  chk_read_nack: assert property (s_rd_nodata |=> !sda_oe_reg && state_reg == ST_IDLE)
    else $error("read header acked without data");
  chk_stretch_hold: assert property (state_reg == ST_HOLD |-> scl_oe_reg)
    else $error("clock not held while waiting");
  chk_hold_release: assert property (s_hold_done |=> s_release)
    else $error("clock not released after data");
  chk_meas_start: assert property (meas_go |=> meas_start_reg)
    else $error("measurement not started on command");
  chk_single_once: assert property (meas_start_reg && !periodic_reg |-> $past(meas_go))
    else $error("extra single-shot measurement");
  chk_crc_bytes: assert property (load_w && !stop_det && !start_det |=>
    tx_buf_reg[31:24] == crc8(tx_buf_reg[47:32]) && tx_buf_reg[7:0] == crc8(tx_buf_reg[23:8]))
    else $error("checksum byte mismatch");
  chk_nack_stops: assert property (state_reg == ST_MACK && scl_rise && sda_s
    && !stop_det |=> state_reg == ST_IDLE && !sda_oe_reg)
    else $error("sending continued after nack");
  chk_break_abort: assert property (brk_go |=> meas_abort_reg && !periodic_reg
    && !store_valid_reg)
    else $error("break did not abort");
  chk_bad_cmd: assert property (byte_done && phase_reg == PH_LSB && !cmd_ok
    && !stop_det && !start_det |=> !sda_oe_reg)
    else $error("unknown command acked");
  chk_fetch_clear: assert property (load_w && !pop |=> !store_valid_reg)
    else $error("stored result not cleared");
  chk_art_mode: assert property (meas_go && cmd_word == ART_CMD |=> periodic_reg
    && rate_reg == RATE_ART && !stretch_reg)
    else $error("accelerated mode not entered");
endmodule
`default_nettype wire

// ===== include/rhtm_pkg.sv
/*
  Constants, command tables and state type for the humidity and
  temperature command and readout block.
  Assumes a 250 MHz core clock; shared by the core and its testbench.
*/
package rhtm_pkg;

  // Bus addresses selected by the address-select pin
  localparam logic [6:0] ADDR_LO = 7'h44;
  localparam logic [6:0] ADDR_HI = 7'h45;

  // Single-shot commands, LSB order: high, medium, low repeatability
  localparam logic [7:0] SS_MSB_STR   = 8'h2c;
  localparam logic [7:0] SS_MSB_NOSTR = 8'h24;
  localparam logic [7:0] SS_LSB_STR   [3] = '{8'h06, 8'h0d, 8'h10};
  localparam logic [7:0] SS_LSB_NOSTR [3] = '{8'h00, 8'h0b, 8'h16};

  // Periodic commands by rate: 0.5, 1, 2, 4, 10 per second
  localparam int unsigned NUM_RATES = 5;
  localparam logic [7:0] PER_MSB [5] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h27};
  localparam logic [7:0] PER_LSB [5][3] = '{
    '{8'h32, 8'h24, 8'h2f}, '{8'h30, 8'h26, 8'h2d}, '{8'h36, 8'h20, 8'h2b},
    '{8'h34, 8'h22, 8'h29}, '{8'h37, 8'h21, 8'h2a}};
  localparam logic [15:0] ART_CMD  = 16'h2b32;
  localparam logic [2:0]  RATE_ART = 3'h5;

  // Periodic scheduling: a 50 ms base tick, then ticks per period
  localparam int unsigned CLK_MHZ     = 250;
  localparam int unsigned TICK_MS     = 50;
  localparam int unsigned TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
  localparam logic [5:0]  PER_TICKS [6] = '{6'h28, 6'h14, 6'h0a, 6'h05, 6'h02, 6'h05};

  // Transfer phases and counts
  localparam logic [1:0] PH_ADDR   = 2'h0;
  localparam logic [1:0] PH_MSB    = 2'h1;
  localparam logic [1:0] PH_LSB    = 2'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [2:0] LAST_BYTE = 3'h5;

  // Result buffer
  localparam int unsigned PAIR_W     = 32;
  localparam int unsigned FIFO_DEPTH = 4;

  // Checksum defaults
  localparam logic [7:0] CRC_POLY_DEF = 8'h31;
  localparam logic [7:0] CRC_INIT_DEF = 8'hff;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_ACK, ST_HOLD, ST_REL, ST_SEND, ST_MACK, ST_NEXT
  } rhtm_state_type;

endpackage

// ===== hw/rhtm_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides and a flush.
  Assumes a single clock; DEPTH is a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module rhtm_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push;
  wire              pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== tb/rhtm_master_model.sv
/*
  Behavioural two-wire bus master for the sensor block.
  Assumes the bench resolves SCL and SDA with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module rhtm_master_model (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic hp(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves mid-low so it is never seen as start or stop
  task automatic bit_io(input logic b, output logic r);
    hp(2);
    sda_low = !b;
    hp(2);
    scl_low = 1'b0;
    wait (scl === 1'b1);
    hp(4);
    r = sda;
    scl_low = 1'b1;
  endtask
  task automatic start();
    hp(2);
    sda_low = 1'b1;
    hp(4);
    scl_low = 1'b1;
  endtask
  task automatic stop();
    hp(2);
    sda_low = 1'b1;
    hp(2);
    scl_low = 1'b0;
    hp(4);
    sda_low = 1'b0;
    hp(4);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!ack, r);
  endtask
endmodule
`default_nettype wire

// ===== tb/rh_temp_measure_commands_test.sv
/*
  Self-checking bench for the sensor command and readout block.
  Assumes the master model and a bench measurement engine.
*/
`timescale 1ns/1ps
`default_nettype none
module rh_temp_measure_commands_test;
  import rhtm_pkg::*;
  localparam int unsigned TICK = 20;
  localparam logic [15:0] BRK = 16'hb0b0;
  localparam logic [15:0] FET = 16'hf0f0;
  // Far shorter than the real wait to keep the run short
  localparam int MIN_WAIT = 40;
  logic        clk = 1'b0, nrst = 1'b0, addr_sel = 1'b0, res_valid = 1'b0;
  logic        took = 1'b0, pend = 1'b0, stretched = 1'b0, aborted = 1'b0;
  logic        res_ready, scl_oe, sda_oe, scl_out, sda_out, meas_start, meas_abort;
  logic        periodic_mode, data_present, m_scl_low, m_sda_low;
  logic [1:0]  meas_rep;
  logic [15:0] res_temp = 16'h0, res_hum = 16'h0, pair_n = 16'h0;
  int          bad_count = 0, cmp_count = 0, eng_delay = 0, wait_cnt = 0;
  int          starts = 0, cyc = 0, last_st = 0, period = 0;
  wire logic   scl = !(scl_oe | m_scl_low);
  wire logic   sda = !(sda_oe | m_sda_low);

  rhtm_sensor_if #(.TICK_CYCLES(TICK), .BREAK_CMD(BRK), .FETCH_CMD(FET)) dut_u (
    .clk(clk), .nrst(nrst), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .res_valid(res_valid), .res_ready(res_ready), .res_temp(res_temp),
    .res_hum(res_hum), .meas_start(meas_start), .meas_abort(meas_abort),
    .meas_rep(meas_rep), .periodic_mode(periodic_mode), .data_present(data_present));
  rhtm_master_model mst_u (.clk(clk), .scl(scl), .sda(sda),
    .scl_low(m_scl_low), .sda_low(m_sda_low));

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    took <= res_valid && res_ready;
    if (meas_start === 1'b1) begin
      starts <= starts + 1;
      period <= cyc - last_st;
      last_st <= cyc;
    end
    if (scl_oe === 1'b1) stretched <= 1'b1;
    if (meas_abort === 1'b1) aborted <= 1'b1;
  end
  // Engine: one pair eng_delay cycles after the latest start
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (meas_start === 1'b1) begin
      pend <= 1'b1;
      wait_cnt <= eng_delay;
    end else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    if (took) begin
      res_valid <= 1'b0;
      pair_n <= pair_n + 16'h1;
    end else if (pend && wait_cnt == 0 && !res_valid) begin
      res_valid <= 1'b1;
      pend <= 1'b0;
      res_temp <= 16'h6a00 + pair_n;
      res_hum <= 16'h9c40 ^ pair_n;
    end
    if (meas_abort === 1'b1) begin
      pend <= 1'b0;
      res_valid <= 1'b0;
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT_DEF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY_DEF : 8'h0);
    return c;
  endfunction
  task automatic cmd(input logic [6:0] a, input logic [15:0] c, output logic [2:0] ak);
    ak = 3'h0;
    mst_u.start();
    mst_u.wbyte({a, 1'b0}, ak[2]);
    if (ak[2]) mst_u.wbyte(c[15:8], ak[1]);
    if (ak[1]) mst_u.wbyte(c[7:0], ak[0]);
    mst_u.stop();
    repeat (MIN_WAIT) @(negedge clk);
  endtask
  task automatic read_pair(input logic [15:0] k, input int n, output logic hdr);
    logic [7:0]  b;
    logic [7:0]  exp [6];
    logic [15:0] t;
    logic [15:0] h;
    t = 16'h6a00 + k;
    h = 16'h9c40 ^ k;
    exp = '{t[15:8], t[7:0], crc8(t), h[15:8], h[7:0], crc8(h)};
    mst_u.start();
    mst_u.wbyte({addr_sel ? ADDR_HI : ADDR_LO, 1'b1}, hdr);
    for (int i = 0; i < n && hdr; i++) begin
      mst_u.rbyte(i < n - 1, b);
      check(16'(b), 16'(exp[i]), "read byte");
    end
    if (hdr && n < 6) begin
      mst_u.rbyte(1'b0, b);
      check(16'(b), 16'hff, "after nack");
    end
    mst_u.stop();
  endtask

  task automatic t_single(input logic str);
    logic [2:0]  a;
    logic        h;
    logic [15:0] k;
    eng_delay = 300;
    for (int r = 0; r < 3; r++) begin
      k = pair_n;
      stretched = 1'b0;
      if (str) cmd(ADDR_LO, {SS_MSB_STR, SS_LSB_STR[r]}, a);
      else cmd(ADDR_LO, {SS_MSB_NOSTR, SS_LSB_NOSTR[r]}, a);
      check(16'(a), 16'h7, "cmd ack");
      check(16'(meas_rep), 16'(r), "rep");
      if (!str) begin
        read_pair(k, 6, h);
        check(16'(h), 16'h0, "early header");
        for (int i = 0; i < 2000 && data_present !== 1'b1; i++) @(negedge clk);
      end
      read_pair(k, (r == 1) ? 2 : 6, h);
      check(16'(h), 16'h1, "data header");
      check(16'(stretched), 16'(str), "stretch");
      read_pair(k, 6, h);
      check(16'(h), 16'h0, "second read");
    end
  endtask
  task automatic t_addr();
    logic [2:0] a;
    int         s;
    addr_sel = 1'b1;
    s = starts;
    repeat (4) @(negedge clk);
    cmd(ADDR_LO, {SS_MSB_NOSTR, SS_LSB_NOSTR[0]}, a);
    check(16'(a), 16'h0, "wrong addr");
    cmd(ADDR_HI, 16'h1234, a);
    check(16'(a), 16'h6, "unknown cmd");
    check(16'(starts - s), 16'h0, "no start");
    addr_sel = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_periodic();
    logic [2:0] a;
    int         rt;
    int         s;
    eng_delay = 10;
    for (int q = 0; q < 16; q++) begin
      rt = q / 3;
      aborted = 1'b0;
      cmd(ADDR_LO, (rt < 5) ? {PER_MSB[rt], PER_LSB[rt][q % 3]} : ART_CMD, a);
      check(16'(periodic_mode), 16'h1, "periodic on");
      check(16'(meas_rep), (rt < 5) ? 16'(q % 3) : 16'h0, "rep");
      s = starts;
      for (int i = 0; i < 3000 && starts < s + 2; i++) @(negedge clk);
      check(16'(period), 16'(TICK * PER_TICKS[rt]), "period");
      cmd(ADDR_LO, BRK, a);
      check({13'h0, periodic_mode, data_present, aborted}, 16'h1, "break");
    end
  endtask
  task automatic t_fetch();
    logic [2:0]  a;
    logic        h;
    logic [15:0] k;
    eng_delay = 5000;
    cmd(ADDR_LO, ART_CMD, a);
    cmd(ADDR_LO, FET, a);
    check(16'(a), 16'h7, "fetch ack");
    read_pair(16'h0, 6, h);
    check(16'(h), 16'h0, "empty fetch");
    k = pair_n;
    eng_delay = 10;
    for (int i = 0; i < 3000 && res_ready !== 1'b0; i++) @(negedge clk);
    check(16'(res_ready), 16'h0, "buffer full");
    for (int j = 0; j < 2; j++) begin
      cmd(ADDR_LO, FET, a);
      read_pair(k + 16'(j), 6, h);
      check(16'(h), 16'h1, "fetch read");
    end
    cmd(ADDR_LO, BRK, a);
    check({14'h0, res_ready, data_present}, 16'h2, "flushed");
  endtask

  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    check({9'h0, scl_out, sda_out, scl_oe, sda_oe, periodic_mode, data_present, res_ready},
          16'h1, "reset");
    // Scenarios race the cycle ceiling; a hang still reaches the report
    fork
      begin
        t_single(1'b0);
        t_single(1'b1);
        t_addr();
        t_periodic();
        t_fetch();
      end
      begin
        wait (cyc > 80000);
        bad_count++;
        $display("BAD %0t run timed out", $time);
      end
    join_any
    report_and_stop();
  end
endmodule
`default_nettype wire
